/* File: src/ebz_top.sv */
// zoned external bus timing: register file on AXI4-Lite plus the lead/active/trail sequencer
// assumes acc_* requests come from the processor side in the aclk domain and wait for acc_done
`timescale 1ns/1ps

module ebz_top
(
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [ebz_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [ebz_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      acc_req,
  input  wire logic [2:0]                acc_zone,
  input  wire logic                      acc_write,
  input  wire logic                      ext_wait_input,
  output logic [7:0]                     zone_select_n,
  output logic                           read_strobe_n,
  output logic                           write_strobe_n,
  output logic                           acc_done,
  output logic [1:0]                     acc_phase
);
  import ebz_pkg::*;

  logic [31:0] timing_reg [0:7];
  logic [31:0] config_reg;
  logic [31:0] bank_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  ebz_phase_e  phase_reg;
  logic [31:0] latched_reg;
  logic        lat_write_reg;
  logic        lat_tclk_reg;

  logic        aw_ok;
  logic        w_ok;
  logic        do_write;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [31:0] rd_value;
  logic        rd_mapped;
  logic        wr_mapped;
  logic        ready_seen;
  logic        cnt_last;
  logic        cnt_load;
  logic [5:0]  cnt_val;
  logic        lat_scale;
  logic        wait_gate;
  logic [1:0]  lead_f;
  logic [2:0]  act_f;
  logic [1:0]  trail_f;
  logic [5:0]  trail_cycles;
  logic [2:0]  acc_zone_hold;
  logic [2:0]  wr_zone;
  logic        wr_zone_hit;

  // merge byte lanes into a stored value, keeping only implemented bits
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge_strb = ((old_v & ~m) | (new_v & m)) & mask;
  endfunction

  // zones with a live timing register
  function automatic logic zone_live(input logic [2:0] z);
    zone_live = (z <= 3'h2) || (z >= 3'h6);
  endfunction

  // whether a byte address is a timing slot, and its zone number if so
  function automatic logic zone_addr(input logic [ADDR_W-1:0] a, output logic [2:0] z);
    logic hit;
    hit = 1'b0;
    z = 3'h0;
    for (int i = 0; i < 8; i++)
    begin
      if (a == ebz_byte_addr(ZONE0_TIMING_IDX + 16'(2 * i)))
      begin
        hit = 1'b1;
        z = 3'(i);
      end
    end
    zone_addr = hit;
  endfunction

  // write channel acceptance: each channel held until both are present
  assign aw_ok    = s_axi_awvalid && s_axi_awready;
  assign w_ok     = s_axi_wvalid && s_axi_wready;
  assign wr_addr  = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  assign wr_data  = w_held_reg ? wdata_reg : s_axi_wdata;
  assign wr_strb  = w_held_reg ? wstrb_reg : s_axi_wstrb;
  assign do_write = (aw_held_reg || aw_ok) && (w_held_reg || w_ok) && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= '0;
      wdata_reg     <= 32'h00000000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      if (do_write)
        aw_held_reg <= 1'b0;
      else if (aw_ok)
        aw_held_reg <= 1'b1;
      if (do_write)
        w_held_reg <= 1'b0;
      else if (w_ok)
        w_held_reg <= 1'b1;
      if (aw_ok)
        awaddr_reg <= s_axi_awaddr;
      if (w_ok)
      begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      // ready drops once a beat is held or a response is pending
      s_axi_awready <= !(aw_held_reg || aw_ok) && !do_write && !s_axi_bvalid;
      s_axi_wready  <= !(w_held_reg || w_ok) && !do_write && !s_axi_bvalid;
    end
  end

  // write decode; reserved slots answer okay but store nothing
  always_comb
  begin
    wr_zone     = 3'h0;
    wr_zone_hit = zone_addr(wr_addr, wr_zone);
    wr_mapped   = wr_zone_hit
             || (wr_addr == ebz_byte_addr(CONFIG_FIRST_IDX))
             || (wr_addr == ebz_byte_addr(INTERFACE_CONFIG_IDX))
             || (wr_addr == ebz_byte_addr(BANK_CONTROL_IDX))
             || (wr_addr == ebz_byte_addr(REVISION_IDX));
  end

  // per-zone timing storage, written independently
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 8; i++)
        timing_reg[i] <= zone_live(3'(i)) ? TIMING_RESET : 32'h00000000;
    end
    else if (do_write && wr_zone_hit && zone_live(wr_zone))
      timing_reg[wr_zone] <= merge_strb(timing_reg[wr_zone], wr_data, wr_strb, TIMING_MASK);
  end

  // interface config and bank control
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      config_reg <= CFG_RESET;
      bank_reg   <= BANK_RESET;
    end
    else if (do_write)
    begin
      if (wr_addr == ebz_byte_addr(INTERFACE_CONFIG_IDX))
        config_reg <= merge_strb(config_reg, wr_data, wr_strb, CFG_MASK);
      if (wr_addr == ebz_byte_addr(BANK_CONTROL_IDX))
        bank_reg <= merge_strb(bank_reg, wr_data, wr_strb, BANK_MASK);
    end
  end

  // write response one cycle after both beats are in
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // read decode; busy flag shows the sequencer's own state
  always_comb
  begin
    logic [2:0] z;
    z = 3'h0;
    rd_value  = 32'h00000000;
    rd_mapped = 1'b1;
    if (zone_addr(s_axi_araddr, z))
      rd_value = timing_reg[z];
    else if (s_axi_araddr == ebz_byte_addr(INTERFACE_CONFIG_IDX))
    begin
      rd_value = config_reg;
      rd_value[CFG_BUSY_BIT] = (phase_reg != EBZ_IDLE);
    end
    else if (s_axi_araddr == ebz_byte_addr(BANK_CONTROL_IDX))
      rd_value = bank_reg;
    else if (s_axi_araddr == ebz_byte_addr(REVISION_IDX))
      rd_value = {16'h0000, REVISION_VALUE};
    else if (s_axi_araddr != ebz_byte_addr(CONFIG_FIRST_IDX))
      rd_mapped = 1'b0;
  end

  // read channel: address taken when no data is pending, data next cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_value;
        s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // fields of the snapshot taken at access start
  assign lat_scale = latched_reg[TM_SCALE_BIT];
  assign lead_f    = lat_write_reg ? latched_reg[WR_LEAD_LSB +: 2] : latched_reg[RD_LEAD_LSB +: 2];
  assign act_f     = lat_write_reg ? latched_reg[WR_ACT_LSB +: 3] : latched_reg[RD_ACT_LSB +: 3];
  assign trail_f   = lat_write_reg ? latched_reg[WR_TRAIL_LSB +: 2] : latched_reg[RD_TRAIL_LSB +: 2];
  assign trail_cycles = ebz_edge_cycles(trail_f, lat_scale, lat_tclk_reg);
  // mode bit only matters behind the enable
  assign wait_gate = latched_reg[TM_WAIT_EN_BIT] ? ready_seen : 1'b1;

  ebz_wait_sync u_wait_sync
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .wait_in   (ext_wait_input),
    .async_sel (latched_reg[TM_ASYNC_BIT]),
    .ready_out (ready_seen)
  );

  // counter loads at each phase entry
  always_comb
  begin
    cnt_load = 1'b0;
    cnt_val  = CNT_ONE;
    unique case (phase_reg)
      EBZ_IDLE:
      begin
        cnt_load = acc_req && zone_live(acc_zone);
        cnt_val  = ebz_edge_cycles(acc_write ? timing_reg[acc_zone][WR_LEAD_LSB +: 2]
                                             : timing_reg[acc_zone][RD_LEAD_LSB +: 2],
                                   timing_reg[acc_zone][TM_SCALE_BIT], config_reg[CFG_TIMCLK_BIT]);
      end
      EBZ_LEAD:
      begin
        cnt_load = cnt_last;
        cnt_val  = ebz_active_cycles(act_f, lat_scale, lat_tclk_reg);
      end
      EBZ_ACTIVE:
      begin
        cnt_load = cnt_last && wait_gate;
        cnt_val  = trail_cycles;
      end
      EBZ_TRAIL:
      begin
        cnt_load = 1'b0;
        cnt_val  = CNT_ONE;
      end
    endcase
  end

  ebz_phase_counter #(.CNT_W(6)) u_phase_counter
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .load     (cnt_load),
    .load_val (cnt_val),
    .last     (cnt_last)
  );

  // access sequencer; timing is frozen for the whole access
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase_reg     <= EBZ_IDLE;
      latched_reg   <= TIMING_RESET;
      lat_write_reg <= 1'b0;
      lat_tclk_reg  <= 1'b1;
      acc_done      <= 1'b0;
    end
    else
    begin
      acc_done <= 1'b0;
      unique case (phase_reg)
        EBZ_IDLE:
          if (acc_req)
          begin
            if (zone_live(acc_zone))
            begin
              latched_reg   <= timing_reg[acc_zone];
              lat_write_reg <= acc_write;
              lat_tclk_reg  <= config_reg[CFG_TIMCLK_BIT];
              phase_reg     <= EBZ_LEAD;
            end
            else
              acc_done <= 1'b1; // reserved zone completes with no strobe
          end
        EBZ_LEAD:
          if (cnt_last)
            phase_reg <= EBZ_ACTIVE;
        EBZ_ACTIVE:
          // minimum stretch then held while ready is low
          if (cnt_last && wait_gate)
          begin
            if (trail_cycles == 6'h00)
            begin
              phase_reg <= EBZ_IDLE;
              acc_done  <= 1'b1;
            end
            else
              phase_reg <= EBZ_TRAIL;
          end
        EBZ_TRAIL:
          if (cnt_last)
          begin
            phase_reg <= EBZ_IDLE;
            acc_done  <= 1'b1;
          end
      endcase
    end
  end

  // strobe pins follow the phase one cycle later, all registered
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      zone_select_n  <= 8'hff;
      read_strobe_n  <= 1'b1;
      write_strobe_n <= 1'b1;
      acc_phase      <= EBZ_IDLE;
    end
    else
    begin
      zone_select_n  <= 8'hff;
      acc_phase      <= phase_reg;
      read_strobe_n  <= !((phase_reg == EBZ_ACTIVE) && !lat_write_reg);
      write_strobe_n <= !((phase_reg == EBZ_ACTIVE) && lat_write_reg);
      if (phase_reg != EBZ_IDLE)
        zone_select_n <= ~(8'h01 << acc_zone_hold);
    end
  end

  // zone of the running access
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      acc_zone_hold <= 3'h0;
    else if (phase_reg == EBZ_IDLE && acc_req)
      acc_zone_hold <= acc_zone;
  end
endmodule

/* File: shared/ebz_pkg.sv */
// constants, field layout and helpers for the zoned external bus timing block
// assumes one system clock; register indices are word indices, byte address is four times the index
package ebz_pkg;
  // register word indices and byte address
  localparam logic [15:0] ZONE0_TIMING_IDX     = 16'h0b20;
  localparam logic [15:0] ZONE1_TIMING_IDX     = 16'h0b22;
  localparam logic [15:0] ZONE2_TIMING_IDX     = 16'h0b24;
  localparam logic [15:0] ZONE3_SLOT_IDX       = 16'h0b26;
  localparam logic [15:0] ZONE4_SLOT_IDX       = 16'h0b28;
  localparam logic [15:0] ZONE5_SLOT_IDX       = 16'h0b2a;
  localparam logic [15:0] ZONE6_TIMING_IDX     = 16'h0b2c;
  localparam logic [15:0] ZONE7_TIMING_IDX     = 16'h0b2e;
  localparam logic [15:0] CONFIG_FIRST_IDX     = 16'h0b32;
  localparam logic [15:0] INTERFACE_CONFIG_IDX = 16'h0b34;
  localparam logic [15:0] BANK_CONTROL_IDX     = 16'h0b38;
  localparam logic [15:0] REVISION_IDX         = 16'h0b3a;
  localparam int unsigned ADDR_W               = 16;

  // zone timing register fields
  localparam int unsigned TM_SCALE_BIT   = 22;
  localparam int unsigned TM_WIDTH_LSB   = 16;
  localparam int unsigned TM_ASYNC_BIT   = 15;
  localparam int unsigned TM_WAIT_EN_BIT = 14;
  localparam int unsigned RD_LEAD_LSB    = 12;
  localparam int unsigned RD_ACT_LSB     = 9;
  localparam int unsigned RD_TRAIL_LSB   = 7;
  localparam int unsigned WR_LEAD_LSB    = 5;
  localparam int unsigned WR_ACT_LSB     = 2;
  localparam int unsigned WR_TRAIL_LSB   = 0;
  localparam logic [31:0] TIMING_MASK    = 32'h0043ffff;
  localparam logic [31:0] TIMING_RESET   = 32'h0043ffff;

  // interface config, bank control, revision
  localparam int unsigned CFG_TIMCLK_BIT = 0;
  localparam int unsigned CFG_BUSY_BIT   = 16;
  localparam logic [31:0] CFG_MASK       = 32'h00000001;
  localparam logic [31:0] CFG_RESET      = 32'h00000001;
  localparam logic [31:0] BANK_MASK      = 32'h0000ffff;
  localparam logic [31:0] BANK_RESET     = 32'h00000000;
  localparam logic [15:0] REVISION_VALUE = 16'h0a5c; // arbitrary value

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [5:0] CNT_ONE     = 6'h01;

  typedef enum logic [1:0] {
    EBZ_IDLE   = 2'b00,
    EBZ_LEAD   = 2'b01,
    EBZ_ACTIVE = 2'b10,
    EBZ_TRAIL  = 2'b11
  } ebz_phase_e;

  // byte address of a register index
  function automatic logic [ADDR_W-1:0] ebz_byte_addr(input logic [15:0] idx);
    ebz_byte_addr = {idx[13:0], 2'b00};
  endfunction

  // lead or trail length in system clocks
  function automatic logic [5:0] ebz_edge_cycles(input logic [1:0] v, input logic scale, input logic tclk);
    ebz_edge_cycles = {4'h0, v} << ({1'b0, scale} + {1'b0, tclk});
  endfunction

  // active length in system clocks, implied cycle included
  function automatic logic [5:0] ebz_active_cycles(input logic [2:0] v, input logic scale, input logic tclk);
    logic [5:0] base;
    base = {3'h0, v} << ({1'b0, scale} + {1'b0, tclk});
    ebz_active_cycles = base + (tclk ? 6'h02 : 6'h01);
  endfunction
endpackage

/* File: src/ebz_wait_sync.sv */
// ready input conditioning: direct path for synchronous zones, two-flop path for asynchronous ones
// assumes wait_in may change at any time when used asynchronously
`timescale 1ns/1ps
module ebz_wait_sync
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic wait_in,
  input  wire logic async_sel,
  output logic      ready_out
);
  logic meta_reg;
  logic sync_reg;

  // two-flop synchroniser; first stage feeds only the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= wait_in;
      sync_reg <= meta_reg;
    end
  end

  // async mode costs two cycles of latency on the ready edge
  assign ready_out = async_sel ? sync_reg : wait_in;
endmodule

/* File: src/ebz_phase_counter.sv */
// down counter for one access phase; reports the last cycle of the phase
// assumes load and run are never asked in the same cycle by the owner
`timescale 1ns/1ps
module ebz_phase_counter
#(
  parameter int unsigned CNT_W = 6
)
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  output logic                  last
);
  logic [CNT_W-1:0] cnt_reg;

  // zero or one both mean the phase ends now, so illegal values never hang
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_reg <= '0;
    else if (load)
      cnt_reg <= load_val;
    else if (cnt_reg > CNT_W'(1))
      cnt_reg <= cnt_reg - CNT_W'(1);
  end

  assign last = (cnt_reg <= CNT_W'(1));
endmodule

/* File: verification/ebz_top_asserts.sv */
// port checker for the zoned external bus timing block
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
module ebz_top_asserts
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [7:0]  zone_select_n,
  input wire logic        read_strobe_n,
  input wire logic        write_strobe_n,
  input wire logic        acc_done,
  input wire logic [1:0]  acc_phase
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // address and data taken together, or a read address taken
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // an access leaves idle
  sequence s_leave_idle;
    acc_phase == 2'd0 ##1 acc_phase != 2'd0;
  endsequence

  a_wr_answer: assert property (s_wr_taken |=> s_axi_bvalid)
    else $error("write response missing after address and data");
  a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data missing after read address");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed");
  a_strobe_excl: assert property (read_strobe_n || write_strobe_n)
    else $error("read and write strobes low together");
  a_zone_onehot: assert property (zone_select_n != 8'hff |-> $onehot(~zone_select_n))
    else $error("more than one zone selected");
  a_spare_zones: assert property (zone_select_n[5:3] == 3'b111)
    else $error("reserved zone selected");
  a_read_active: assert property (!read_strobe_n |-> acc_phase == 2'd2)
    else $error("read strobe outside active phase");
  a_done_pulse: assert property (acc_done |=> !acc_done)
    else $error("done longer than one cycle");
  a_lead_first: assert property (s_leave_idle |-> acc_phase == 2'd1)
    else $error("access did not start with lead");
endmodule

/* File: verification/ebz_ext_device.sv */
// external device model: holds ready low for a set number of strobe cycles
// assumes active low strobes and a ready line with a pull-up
`timescale 1ns/1ps
module ebz_ext_device
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  input  wire logic [3:0] stall_cycles,
  output logic            ext_wait_input
);
  logic [3:0] busy_cnt_reg;

  // count strobe cycles, restart when both strobes are released
  always_ff @(posedge aclk)
  begin
    if (!aresetn || (read_strobe_n && write_strobe_n))
      busy_cnt_reg <= 4'h0;
    else if (busy_cnt_reg != 4'hf)
      busy_cnt_reg <= busy_cnt_reg + 4'h1;
  end

  // released line rises to the pull-up level, not the last driven value
  assign ext_wait_input = (read_strobe_n && write_strobe_n) ? 1'b1 : (busy_cnt_reg >= stall_cycles);
endmodule

/* File: verification/ext_bus_zone_timing_config_bench.sv */
// self-checking bench: register map over AXI4-Lite and strobe timing per zone
// assumes the block, its checker and the external device model are compiled first
`timescale 1ns/1ps
module ext_bus_zone_timing_config_bench;
  import ebz_pkg::*;
  logic                aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0]   s_axi_awaddr, s_axi_araddr;
  logic [31:0]         s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]          s_axi_wstrb, stall_cycles;
  logic [1:0]          s_axi_bresp, s_axi_rresp, acc_phase, rs;
  logic                acc_req, acc_write, ext_wait_input, read_strobe_n, write_strobe_n, acc_done;
  logic [2:0]          acc_zone;
  logic [7:0]          zone_select_n;
  int                  fails, n_tests, len;
  logic [15:0] ridx [12] = '{ZONE0_TIMING_IDX, ZONE1_TIMING_IDX, ZONE2_TIMING_IDX, ZONE3_SLOT_IDX,
    ZONE4_SLOT_IDX, ZONE5_SLOT_IDX, ZONE6_TIMING_IDX, ZONE7_TIMING_IDX, CONFIG_FIRST_IDX,
    INTERFACE_CONFIG_IDX, BANK_CONTROL_IDX, REVISION_IDX};
  logic [31:0] rexp [12] = '{32'h0043ffff, 32'h0043ffff, 32'h0043ffff, 32'h0, 32'h0, 32'h0,
    32'h0043ffff, 32'h0043ffff, 32'h0, 32'h1, 32'h0, {16'h0, REVISION_VALUE}};
  int act_a [5] = '{7, 4, 4, 4, 2};
  int act_s [5] = '{1, 0, 1, 0, 1};
  int act_t [5] = '{1, 1, 1, 0, 0};
  int act_n [5] = '{30, 10, 18, 5, 5};

  ebz_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .acc_req, .acc_zone, .acc_write, .ext_wait_input, .zone_select_n,
    .read_strobe_n, .write_strobe_n, .acc_done, .acc_phase);
  ebz_ext_device dev_u (.aclk, .aresetn, .read_strobe_n, .write_strobe_n, .stall_cycles, .ext_wait_input);

  // free-running system clock
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // address and data offered together, each released once taken
  task automatic axi_wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
    bit aw, w, b;
    @(posedge aclk);
    s_axi_awaddr <= idx << 2;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int k = 0; k < 100 && !(aw && w); k++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    for (int k = 0; k < 100 && !b; k++)
    begin
      @(posedge aclk);
      b = s_axi_bvalid;
    end
    s_axi_bready <= 1'b0;
    check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic axi_rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
    bit a, v;
    @(posedge aclk);
    s_axi_araddr <= idx << 2;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int k = 0; k < 100 && !a; k++)
    begin
      @(posedge aclk);
      a = s_axi_arready;
    end
    s_axi_arvalid <= 1'b0;
    for (int k = 0; k < 100 && !v; k++)
    begin
      @(posedge aclk);
      v = s_axi_rvalid;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // one access; returns the number of cycles a strobe was low
  task automatic run_acc(input logic [2:0] z, input logic wr, output int n);
    bit dn;
    n = 0;
    @(posedge aclk);
    acc_zone <= z;
    acc_write <= wr;
    acc_req <= 1'b1;
    @(posedge aclk);
    acc_req <= 1'b0;
    for (int k = 0; k < 200 && !dn; k++)
    begin
      @(posedge aclk);
      dn = acc_done;
      n += !(read_strobe_n && write_strobe_n);
    end
    check("acc_done", {31'h0, dn}, 32'h1);
    @(posedge aclk);
  endtask

  // timing word: width field always ones, lead one, trail zero
  function automatic logic [31:0] tval(input int a, input int sc, input bit en, input bit as);
    return {9'h0, sc[0], 4'h0, 2'b11, as, en, 2'b01, a[2:0], 2'b00, 2'b01, a[2:0], 2'b00};
  endfunction

  // hang guard, 20000 cycles, tens of times the expected run
  initial
  begin
    repeat (20000) @(posedge aclk);
    fails++;
    give_verdict();
  end

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {acc_req, acc_write, acc_zone, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    stall_cycles = 4'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values of the whole map, then an unmapped place
    foreach (ridx[i])
    begin
      axi_rd(ridx[i], rd, rs);
      check("reset value", rd, rexp[i]);
    end
    axi_rd(16'h0b40, rd, rs);
    check("unmapped rresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
    $display("test reset map done");
    // reserved bits, unchecked values, spare slots and read-only places
    axi_wr(ZONE1_TIMING_IDX, 32'hffffffff, RESP_OKAY);
    axi_wr(ZONE2_TIMING_IDX, 32'h0, RESP_OKAY);
    axi_wr(ZONE4_SLOT_IDX, 32'hffffffff, RESP_OKAY);
    axi_wr(REVISION_IDX, 32'h0, RESP_OKAY);
    axi_wr(BANK_CONTROL_IDX, 32'h00001234, RESP_OKAY);
    axi_wr(16'h0b40, 32'h1, RESP_SLVERR);
    axi_rd(ZONE1_TIMING_IDX, rd, rs);
    check("zone1 mask", rd, 32'h0043ffff);
    axi_rd(ZONE2_TIMING_IDX, rd, rs);
    check("zone2 zero", rd, 32'h0);
    axi_rd(ZONE4_SLOT_IDX, rd, rs);
    check("zone4 slot", rd, 32'h0);
    axi_rd(REVISION_IDX, rd, rs);
    check("revision", rd, {16'h0, REVISION_VALUE});
    axi_rd(BANK_CONTROL_IDX, rd, rs);
    check("bank", rd, 32'h00001234);
    axi_rd(ZONE0_TIMING_IDX, rd, rs);
    check("zone0 kept", rd, 32'h0043ffff);
    $display("test register writes done");
    // active length for value, scale and timing clock mode
    for (int i = 0; i < 5; i++)
    begin
      axi_wr(INTERFACE_CONFIG_IDX, act_t[i], RESP_OKAY);
      axi_wr(ZONE0_TIMING_IDX, tval(act_a[i], act_s[i], 0, 0), RESP_OKAY);
      run_acc(3'd0, i[0], len);
      check("active length", len, act_n[i]);
    end
    run_acc(3'd4, 1'b0, len);
    check("spare zone strobe", len, 0);
    $display("test active length done");
    // retiming mid-access applies only from the next access
    axi_wr(INTERFACE_CONFIG_IDX, 32'h1, RESP_OKAY);
    axi_wr(ZONE0_TIMING_IDX, tval(7, 1, 0, 0), RESP_OKAY);
    fork
      run_acc(3'd0, 1'b0, len);
      begin
        repeat (8) @(posedge aclk);
        axi_wr(ZONE0_TIMING_IDX, tval(1, 0, 0, 0), RESP_OKAY);
      end
    join
    check("old timing", len, 30);
    run_acc(3'd0, 1'b0, len);
    check("new timing", len, 4);
    $display("test retiming done");
    // ready ignored when disabled, mode bit irrelevant then; stall extends otherwise
    axi_wr(INTERFACE_CONFIG_IDX, 32'h0, RESP_OKAY);
    stall_cycles <= 4'h6;
    for (int m = 0; m < 4; m++)
    begin
      axi_wr(ZONE6_TIMING_IDX, tval(4, 0, m[1], m[0]), RESP_OKAY);
      run_acc(3'd6, 1'b1, len);
      if (m < 2)
        check("ready ignored", len, 5);
      else
        check("ready stalls", {31'h0, len > 5}, 32'h1);
    end
    $display("test ready sampling done");
    give_verdict();
  end
endmodule

bind ebz_top ebz_top_asserts chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .zone_select_n, .read_strobe_n, .write_strobe_n,
  .acc_done, .acc_phase);
